/* File: wmm_ea_adder.sv */
module wmm_ea_adder (
   input logic [15:0] base_val,
   input logic base_en,
   input logic [15:0] disp,
   input logic disp_en,
   input logic short_form,
   output logic [15:0] sum
);
   import wmm_pkg::*;
   logic [15:0] ofs;

   // Short forms hold a word count; the shift makes it a byte offset
   // word to byte
   assign ofs = !disp_en ? ZERO_WORD :
                short_form ? {10'h000, disp[4:0], 1'b0} : disp;
   assign sum = (base_en ? base_val : ZERO_WORD) + ofs;
endmodule : wmm_ea_adder

/* File: wmm_exec.sv */
// Contract
// - Long load adds address to second register, none when zero, loads first
// - Long load bit 11 set makes the sum point at the address word
// - Word moves keep carry and overflow, set even, negative, zero from word
// - Storage move copies first operand word to second, first stays
// - Immediate to register loads the effective address value itself
// - Immediate to register checks only second word, range and odd indirect only
// - Immediate to storage writes the immediate word, indicators from it
// - Appended address word fetched only for address modes 10 and 11
// - Short forms double the five bit word displacement
// - Short forms add the doubled displacement to the base register
// - Short forms bit 10 set makes the address point at the address word
// - Short store writes register to storage, register kept, flags from it
// - Short load loads storage word to register, storage kept
// - Load then clear loads the word, then writes zero to it
// - Multiply writes low product to register, flags from result
// - Multiply clears overflow, sets it when product exceeds 16 bits
// - Odd indirect or operand address raises specification check
// - Out of range instruction word, short forms and immediate to register first word excepted, or operand raises invalid address check
module wmm_exec (
   input logic sys_clk,
   input logic arst_n,
   input logic start,
   input wmm_pkg::wmm_instr_t instr,
   input logic [15:0] installed_top,
   input logic mem_ack,
   input logic [15:0] mem_rdata,
   input logic reg_load_en,
   input logic [2:0] reg_load_sel,
   input logic [15:0] reg_load_data,
   input logic ind_load_en,
   input wmm_pkg::wmm_ind_t ind_load_val,
   output wmm_pkg::wmm_mem_t mem,
   output logic busy,
   output logic done,
   output logic check_invalid_addr,
   output logic check_spec,
   output wmm_pkg::wmm_ind_t ind,
   output logic [15:0] result_word
);
   import wmm_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_APPEND, S_ADDR, S_PTR, S_CHK, S_READ, S_WRITE, S_FIN
   } wmm_state_t;

   wmm_state_t st_reg, st_next;
   wmm_instr_t ir_reg;
   wmm_mem_t mem_reg;
   wmm_ind_t ind_reg;
   logic [15:0] gpr_reg [8];
   logic idx_reg, busy_reg, done_reg, isa_reg, spec_reg;
   logic chk_isa_reg, chk_spec_reg;
   logic [15:0] ea1_reg, ea2_reg, disp_reg, opnd_reg, result_reg;
   logic issue, issue_we, raise_isa, raise_spec, ea_take;
   logic [15:0] issue_addr, issue_data, ea_val, ea_sum, res_word;
   logic [15:0] product;
   logic mul_ovf;
   logic [2:0] cur_sel;
   logic [1:0] cur_mode;
   logic cur_base_en, cur_disp_en, cur_short, cur_ind;
   logic [15:0] cur_disp;
   logic first_ok, second_ok;

   // Address outside installed storage
   function automatic logic addr_bad(input logic [15:0] a, input logic [15:0] top);
      return a >= top;
   endfunction : addr_bad

   // Forms that read their storage operand
   function automatic logic is_read_op(input wmm_op_t op);
      return op == MOVE_WORD_OP_LONG || op == MOVE_WORD_OP_STOR ||
             op == MOVE_WORD_SHORT_OP_LOAD || op == MOVE_WORD_THEN_CLEAR_OP ||
             op == MULTIPLY_WORD_OP;
   endfunction : is_read_op

   // Forms that write main storage
   function automatic logic is_write_op(input wmm_op_t op);
      return op == MOVE_WORD_OP_STOR || op == MOVE_WORD_IMMEDIATE_OP_STOR ||
             op == MOVE_WORD_SHORT_OP_STORE || op == MOVE_WORD_THEN_CLEAR_OP;
   endfunction : is_write_op

   // Short forms carry no checked instruction word
   function automatic logic is_short(input wmm_op_t op);
      return op == MOVE_WORD_SHORT_OP_STORE || op == MOVE_WORD_SHORT_OP_LOAD;
   endfunction : is_short

   // Operand address source for the operand now being formed
   always_comb begin
      cur_mode = idx_reg ? ir_reg.second_address_mode : ir_reg.first_address_mode;
      cur_sel = idx_reg ? ir_reg.second_base_select : ir_reg.first_base_select;
      cur_base_en = 1'b1;
      cur_disp = idx_reg ? ir_reg.disp2 : ir_reg.disp1;
      cur_disp_en = cur_mode[1];
      cur_short = 1'b0;
      cur_ind = (cur_mode == AM_IND);
      case (ir_reg.op)
         MOVE_WORD_OP_LONG: begin
            cur_sel = ir_reg.second_reg_select;
            cur_base_en = (ir_reg.second_reg_select != NO_BASE_REG);
            cur_disp_en = 1'b1;
            cur_ind = ir_reg.indirect;
         end
         MOVE_WORD_SHORT_OP_STORE, MOVE_WORD_SHORT_OP_LOAD: begin
            cur_disp_en = 1'b1;
            cur_short = 1'b1;
            cur_ind = ir_reg.indirect;
         end
         MOVE_WORD_IMMEDIATE_OP_STOR: begin
            // Displacement comes from the appended word
            cur_disp = disp_reg;
         end
         default: begin
         end
      endcase
   end

   wmm_ea_adder u_ea (
      .base_val(gpr_reg[cur_sel]),
      .base_en(cur_base_en),
      .disp(cur_disp),
      .disp_en(cur_disp_en),
      .short_form(cur_short),
      .sum(ea_sum)
   );

   wmm_multiplier u_mul (
      .multiplier(gpr_reg[ir_reg.first_reg_select]),
      .multiplicand(opnd_reg),
      .product(product),
      .overflow(mul_ovf)
   );

   // Instruction word checks at start; the short forms check only operands
   always_comb begin
      first_ok = is_short(instr.op) || instr.op == MOVE_WORD_IMMEDIATE_OP_REG ||
                 !addr_bad(instr.instr_addr, installed_top);
      second_ok = !(instr.op == MOVE_WORD_OP_LONG ||
                    instr.op == MOVE_WORD_IMMEDIATE_OP_REG ||
                    instr.op == MOVE_WORD_IMMEDIATE_OP_STOR) ||
                  !addr_bad(instr.instr_addr + WORD_STEP, installed_top);
   end

   // Sequencer; every storage access is issued on the way into a wait state
   always_comb begin
      st_next = st_reg;
      issue = 1'b0;
      issue_we = 1'b0;
      issue_addr = ea1_reg;
      issue_data = ZERO_WORD;
      raise_isa = 1'b0;
      raise_spec = 1'b0;
      ea_take = 1'b0;
      ea_val = ea_sum;
      case (st_reg)
         S_IDLE: begin
            if (start) begin
               if (!first_ok || !second_ok) begin
                  raise_isa = 1'b1;
                  st_next = S_FIN;
               end else if (instr.op == MOVE_WORD_IMMEDIATE_OP_STOR &&
                            instr.first_address_mode[1]) begin
                  if (addr_bad(instr.instr_addr + APPEND_OFS, installed_top)) begin
                     raise_isa = 1'b1;
                     st_next = S_FIN;
                  end else begin
                     issue = 1'b1;
                     issue_addr = instr.instr_addr + APPEND_OFS;
                     st_next = S_APPEND;
                  end
               end else begin
                  st_next = S_ADDR;
               end
            end
         end
         S_APPEND: begin
            if (mem_ack) begin
               st_next = S_ADDR;
            end
         end
         S_ADDR: begin
            if (cur_ind) begin
               if (addr_bad(ea_sum, installed_top)) begin
                  raise_isa = 1'b1;
                  st_next = S_FIN;
               end else if (ea_sum[0]) begin
                  raise_spec = 1'b1;
                  st_next = S_FIN;
               end else begin
                  issue = 1'b1;
                  issue_addr = ea_sum;
                  st_next = S_PTR;
               end
            end else begin
               ea_take = 1'b1;
               st_next = (ir_reg.op == MOVE_WORD_OP_STOR && !idx_reg) ? S_ADDR : S_CHK;
            end
         end
         S_PTR: begin
            if (mem_ack) begin
               ea_take = 1'b1;
               ea_val = mem_rdata;
               st_next = (ir_reg.op == MOVE_WORD_OP_STOR && !idx_reg) ? S_ADDR : S_CHK;
            end
         end
         S_CHK: begin
            // no operand access for the immediate load
            if (ir_reg.op == MOVE_WORD_IMMEDIATE_OP_REG) begin
               st_next = S_FIN;
            end else if (addr_bad(ea1_reg, installed_top) ||
                         (ir_reg.op == MOVE_WORD_OP_STOR &&
                          addr_bad(ea2_reg, installed_top))) begin
               raise_isa = 1'b1;
               st_next = S_FIN;
            end else if (ea1_reg[0] || (ir_reg.op == MOVE_WORD_OP_STOR && ea2_reg[0])) begin
               raise_spec = 1'b1;
               st_next = S_FIN;
            end else if (is_read_op(ir_reg.op)) begin
               issue = 1'b1;
               st_next = S_READ;
            end else begin
               issue = 1'b1;
               issue_we = 1'b1;
               issue_data = (ir_reg.op == MOVE_WORD_IMMEDIATE_OP_STOR) ?
                            ir_reg.immediate : gpr_reg[ir_reg.first_reg_select];
               st_next = S_WRITE;
            end
         end
         S_READ: begin
            if (mem_ack) begin
               st_next = S_FIN;
               if (is_write_op(ir_reg.op)) begin
                  issue = 1'b1;
                  issue_we = 1'b1;
                  issue_addr = (ir_reg.op == MOVE_WORD_OP_STOR) ? ea2_reg : ea1_reg;
                  issue_data = (ir_reg.op == MOVE_WORD_OP_STOR) ? mem_rdata : ZERO_WORD;
                  st_next = S_WRITE;
               end
            end
         end
         S_WRITE: begin
            if (mem_ack) begin
               st_next = S_FIN;
            end
         end
         S_FIN: begin
            st_next = S_IDLE;
         end
         default: begin
            st_next = S_IDLE;
         end
      endcase
   end

   // Word that sets the indicators and, except for the storage move and the immediate and short stores, lands in the register
   always_comb begin
      case (ir_reg.op)
         MOVE_WORD_IMMEDIATE_OP_REG: res_word = ea1_reg;
         MOVE_WORD_IMMEDIATE_OP_STOR: res_word = ir_reg.immediate;
         MOVE_WORD_SHORT_OP_STORE: res_word = gpr_reg[ir_reg.first_reg_select];
         MULTIPLY_WORD_OP: res_word = product;
         default: res_word = opnd_reg;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= S_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Instruction, operand index, addresses and read data
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ir_reg <= '0;
         idx_reg <= 1'b0;
         ea1_reg <= ZERO_WORD;
         ea2_reg <= ZERO_WORD;
         disp_reg <= ZERO_WORD;
         opnd_reg <= ZERO_WORD;
      end else begin
         if (st_reg == S_IDLE && start) begin
            ir_reg <= instr;
            idx_reg <= 1'b0;
         end
         if (st_reg == S_APPEND && mem_ack) begin
            disp_reg <= mem_rdata;
         end
         if (ea_take) begin
            if (idx_reg) begin
               ea2_reg <= ea_val;
            end else begin
               ea1_reg <= ea_val;
            end
            idx_reg <= 1'b1;
         end
         if (st_reg == S_READ && mem_ack) begin
            opnd_reg <= mem_rdata;
         end
      end
   end

   // Storage request; held until the acknowledge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_reg <= MEM_IDLE;
      end else if (issue) begin
         mem_reg <= '{req: 1'b1, we: issue_we, addr: issue_addr, wdata: issue_data};
      end else if (mem_ack) begin
         mem_reg.req <= 1'b0;
      end
   end

   // Check flags, held for the whole instruction
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         isa_reg <= 1'b0;
         spec_reg <= 1'b0;
      end else if (st_reg == S_IDLE && !raise_isa) begin
         isa_reg <= 1'b0;
         spec_reg <= 1'b0;
      end else begin
         isa_reg <= isa_reg | raise_isa;
         spec_reg <= spec_reg | raise_spec;
      end
   end

   // General registers; outside loads only while idle so operands stay put
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 8; i++) begin
            gpr_reg[i] <= GPR_RESET;
         end
      end else if (st_reg == S_FIN) begin
         if (!isa_reg && !spec_reg && !is_write_op(ir_reg.op)) begin
            gpr_reg[ir_reg.first_reg_select] <= res_word;
         end else if (!isa_reg && !spec_reg && ir_reg.op == MOVE_WORD_THEN_CLEAR_OP) begin
            gpr_reg[ir_reg.first_reg_select] <= res_word;
         end
      end else if (st_reg == S_IDLE && reg_load_en) begin
         gpr_reg[reg_load_sel] <= reg_load_data;
      end
   end

   // Indicators
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ind_reg <= IND_RESET;
      end else if (st_reg == S_FIN) begin
         if (!isa_reg && !spec_reg) begin
            ind_reg.even <= ~res_word[0];
            ind_reg.negative <= res_word[15];
            ind_reg.zero <= (res_word == ZERO_WORD);
            if (ir_reg.op == MULTIPLY_WORD_OP) begin
               ind_reg.overflow <= mul_ovf;
            end
         end
      end else if (st_reg == S_IDLE && ind_load_en) begin
         ind_reg <= ind_load_val;
      end
   end

   // Completion outputs; done and checks pulse for one cycle after S_FIN, busy and result are held
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         chk_isa_reg <= 1'b0;
         chk_spec_reg <= 1'b0;
         result_reg <= ZERO_WORD;
      end else begin
         done_reg <= (st_reg == S_FIN);
         // Check pulses get their own flops so the outputs carry no gating
         chk_isa_reg <= (st_reg == S_FIN) && isa_reg;
         chk_spec_reg <= (st_reg == S_FIN) && spec_reg;
         busy_reg <= (st_next != S_IDLE);
         if (st_reg == S_FIN && !isa_reg && !spec_reg) begin
            result_reg <= res_word;
         end
      end
   end

   assign mem = mem_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign check_invalid_addr = chk_isa_reg;
   assign check_spec = chk_spec_reg;
   assign ind = ind_reg;
   assign result_word = result_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   carry_hold_a: assert property (done_reg |-> ind_reg.carry == $past(ind_reg.carry))
      else $error("carry changed by instruction");
   zero_flag_a: assert property (done_reg && !isa_reg && !spec_reg |->
      ind_reg.zero == (result_reg == ZERO_WORD))
      else $error("zero indicator disagrees with result");
   check_no_ind_a: assert property (done_reg && (isa_reg || spec_reg) |->
      ind_reg == $past(ind_reg))
      else $error("indicators changed on program check");
   check_no_write_a: assert property (mem_reg.req && mem_reg.we |-> !isa_reg && !spec_reg)
      else $error("storage write during program check");
   even_addr_a: assert property (mem_reg.req |-> !mem_reg.addr[0])
      else $error("odd storage address issued");
   stor_copy_a: assert property (mem_reg.req && mem_reg.we && $past(st_reg) == S_READ &&
      ir_reg.op == MOVE_WORD_OP_STOR |-> mem_reg.addr == ea2_reg &&
      mem_reg.wdata == $past(mem_rdata))
      else $error("storage move wrote wrong word or place");
   clear_zero_a: assert property (mem_reg.req && mem_reg.we &&
      ir_reg.op == MOVE_WORD_THEN_CLEAR_OP |-> mem_reg.wdata == ZERO_WORD &&
      mem_reg.addr == ea1_reg && st_reg == S_WRITE)
      else $error("clear not zero or not after load");
   append_mode_a: assert property (st_reg == S_APPEND |-> ir_reg.first_address_mode[1])
      else $error("appended word fetched for short mode");
   imm_reg_a: assert property (done_reg && !isa_reg && !spec_reg &&
      ir_reg.op == MOVE_WORD_IMMEDIATE_OP_REG |->
      gpr_reg[ir_reg.first_reg_select] == ea1_reg)
      else $error("immediate load did not load address value");
   mul_ovf_a: assert property (done_reg && !isa_reg && !spec_reg &&
      ir_reg.op == MULTIPLY_WORD_OP |-> ind_reg.overflow == $past(mul_ovf))
      else $error("multiply overflow indicator wrong");
   short_disp_a: assert property (st_reg == S_ADDR && is_short(ir_reg.op) |->
      ea_sum == gpr_reg[ir_reg.first_base_select] + {10'h000, ir_reg.disp1[4:0], 1'b0})
      else $error("short address not base plus doubled displacement");

   cov_stor_move_c: cover property (done_reg && ir_reg.op == MOVE_WORD_OP_STOR && !isa_reg);
   cov_mul_ovf_c: cover property (done_reg && ir_reg.op == MULTIPLY_WORD_OP && ind_reg.overflow);
   cov_spec_c: cover property (check_spec);
   cov_clear_c: cover property (done_reg && ir_reg.op == MOVE_WORD_THEN_CLEAR_OP && !spec_reg);
endmodule : wmm_exec

/* File: wmm_multiplier.sv */
module wmm_multiplier (
   input logic [15:0] multiplier,
   input logic [15:0] multiplicand,
   output logic [15:0] product,
   output logic overflow
);
   import wmm_pkg::*;
   logic signed [31:0] full;

   // Full signed product, only the low word is kept
   assign full = $signed(multiplier) * $signed(multiplicand);
   assign product = full[15:0];
   assign overflow = (full[31:15] != {17{full[15]}});
endmodule : wmm_multiplier

/* File: wmm_pkg.sv */
package wmm_pkg;
   // Byte distance between consecutive instruction words
   localparam logic [15:0] WORD_STEP = 16'h0002;
   // Appended address word sits after the immediate word
   localparam logic [15:0] APPEND_OFS = 16'h0004;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // Address mode field codes of the storage operand forms
   localparam logic [1:0] AM_REG = 2'h0;
   localparam logic [1:0] AM_REG_INC = 2'h1;
   localparam logic [1:0] AM_DISP = 2'h2;
   localparam logic [1:0] AM_IND = 2'h3;
   localparam logic [2:0] NO_BASE_REG = 3'h0;
   localparam logic [15:0] GPR_RESET = 16'h0000;

   // Instruction forms handled by the block
   typedef enum logic [2:0] {
      MOVE_WORD_OP_LONG,
      MOVE_WORD_OP_STOR,
      MOVE_WORD_IMMEDIATE_OP_REG,
      MOVE_WORD_IMMEDIATE_OP_STOR,
      MOVE_WORD_SHORT_OP_STORE,
      MOVE_WORD_SHORT_OP_LOAD,
      MOVE_WORD_THEN_CLEAR_OP,
      MULTIPLY_WORD_OP
   } wmm_op_t;

   // Decoded instruction handed over by the fetch stage
   typedef struct packed {
      wmm_op_t op;
      logic [2:0] first_reg_select;
      logic [2:0] second_reg_select;
      logic [2:0] first_base_select;
      logic [2:0] second_base_select;
      logic [1:0] first_address_mode;
      logic [1:0] second_address_mode;
      logic indirect;
      logic [15:0] disp1;
      logic [15:0] disp2;
      logic [15:0] immediate;
      logic [15:0] instr_addr;
   } wmm_instr_t;

   // Processor indicators
   typedef struct packed {
      logic carry;
      logic overflow;
      logic even;
      logic negative;
      logic zero;
   } wmm_ind_t;

   localparam wmm_ind_t IND_RESET = '0;

   // Main storage request
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } wmm_mem_t;

   localparam wmm_mem_t MEM_IDLE = '0;
endpackage : wmm_pkg

/* File: wmm_store_model.sv */
module wmm_store_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire wmm_pkg::wmm_mem_t mem,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import wmm_pkg::*;
   logic [15:0] words [0:255];
   logic [1:0] cnt;
   logic slow;
   int reqs;
   // One word access at a time; the wait alternates between none and two cycles
   // Read data toggles after the ack cycle and while no request is pending so a late sample is never lucky
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
         cnt <= 2'h0;
         slow <= 1'b0;
         reqs <= 0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= 2'h0;
      end else if (mem.req) begin
         cnt <= cnt + 2'h1;
         if (cnt == {slow, 1'b0}) begin
            mem_ack <= 1'b1;
            slow <= ~slow;
            reqs <= reqs + 1;
            mem_rdata <= words[mem.addr[8:1]];
            if (mem.we) begin
               words[mem.addr[8:1]] <= mem.wdata;
            end
         end
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : wmm_store_model

/* File: word_move_multiply_exec_test.sv */
module word_move_multiply_exec_test;
   timeunit 1ns;
   timeprecision 100ps;
   import wmm_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0;
   wmm_instr_t instr = '0;
   logic reg_load_en = 1'b0;
   logic [2:0] reg_load_sel = 3'h0;
   logic [15:0] reg_load_data = 16'h0000;
   logic ind_load_en = 1'b0;
   wmm_ind_t ind_load_val = '0;
   wmm_mem_t mem;
   wmm_ind_t ind;
   logic mem_ack, busy, done, check_invalid_addr, check_spec, ci, cs;
   logic [15:0] mem_rdata, result_word;
   int errors = 0;
   int compares = 0;
   // 125 MHz processor clock
   always #4 sys_clk = ~sys_clk;
   wmm_exec uut (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .instr(instr),
      .installed_top(16'h0100), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .reg_load_en(reg_load_en), .reg_load_sel(reg_load_sel), .reg_load_data(reg_load_data),
      .ind_load_en(ind_load_en), .ind_load_val(ind_load_val), .mem(mem), .busy(busy),
      .done(done), .check_invalid_addr(check_invalid_addr), .check_spec(check_spec),
      .ind(ind), .result_word(result_word));
   wmm_store_model m (.sys_clk(sys_clk), .arst_n(arst_n), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   task automatic wrap_up();
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Unused fields stay zero, so reserved instruction bits are never set
   // reserved bits zero
   function automatic wmm_instr_t mk(input wmm_op_t op, input logic [2:0] r, b,
         input logic [1:0] am, input logic x, input logic [15:0] d1, d2);
      mk = '0;
      mk.op = op;
      mk.first_reg_select = r;
      mk.second_reg_select = b;
      mk.first_base_select = b;
      mk.second_base_select = b;
      mk.first_address_mode = am;
      mk.second_address_mode = am;
      mk.indirect = x;
      mk.disp1 = d1;
      mk.disp2 = d2;
      mk.immediate = d2;
   endfunction : mk
   // Indicators expected from a moved word, carry and overflow given
   function automatic logic [15:0] fx(input logic [1:0] co, input logic [15:0] w);
      fx = {11'h0, co, ~w[0], w[15], w == 16'h0};
   endfunction : fx
   // One instruction: start pulse, bounded wait for done, checks taken with done
   task automatic go(input wmm_instr_t i);
      int n;
      n = 0;
      instr = i;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      chk({14'h0, busy, done}, 16'h2);
      while (done !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      if (done !== 1'b1) begin
         errors++;
         wrap_up();
      end
      chk({14'h0, busy, done}, 16'h1);
      ci = check_invalid_addr;
      cs = check_spec;
      @(negedge sys_clk);
   endtask : go
   task automatic ld(input logic [2:0] s, input logic [15:0] d);
      reg_load_sel = s;
      reg_load_data = d;
      reg_load_en = 1'b1;
      @(negedge sys_clk);
      reg_load_en = 1'b0;
   endtask : ld
   task automatic fl();
      ind_load_val = 5'h18;
      ind_load_en = 1'b1;
      @(negedge sys_clk);
      ind_load_en = 1'b0;
   endtask : fl
   // Main sequence; base register 1 holds 0x40, register 7 the storage top
   initial begin
      wmm_instr_t i;
      logic [15:0] r0;
      int n0;
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      @(negedge sys_clk);
      ld(3'h1, 16'h0040);
      ld(3'h2, 16'h0000);
      ld(3'h7, 16'h0100);
      fl();
      m.words[8'h3f] = 16'h8001;
      go(mk(MOVE_WORD_SHORT_OP_LOAD, 3'h4, 3'h1, AM_REG, 1'b0, 16'h001f, 16'h0));
      chk(result_word, 16'h8001);
      chk({11'h0, ind}, fx(2'b11, 16'h8001));
      chk(m.words[8'h3f], 16'h8001);
      chk({14'h0, ci, cs}, 16'h0);
      m.words[8'h22] = 16'h0090;
      m.words[8'h48] = 16'hffff;
      go(mk(MOVE_WORD_SHORT_OP_STORE, 3'h2, 3'h1, AM_REG, 1'b1, 16'h0002, 16'h0));
      chk(m.words[8'h48], 16'h0000);
      chk({11'h0, ind}, fx(2'b11, 16'h0));
      m.words[8'h30] = 16'h0070;
      m.words[8'h38] = 16'h1234;
      go(mk(MOVE_WORD_OP_LONG, 3'h5, 3'h0, AM_REG, 1'b1, 16'h0060, 16'h0));
      chk(result_word, 16'h1234);
      go(mk(MOVE_WORD_OP_LONG, 3'h5, 3'h1, AM_REG, 1'b0, 16'h0020, 16'h0));
      chk(result_word, 16'h0070);
      m.words[8'h28] = 16'ha5a4;
      go(mk(MOVE_WORD_OP_STOR, 3'h0, 3'h1, AM_DISP, 1'b0, 16'h0010, 16'h0012));
      chk(m.words[8'h29], 16'ha5a4);
      chk(m.words[8'h28], 16'ha5a4);
      chk({11'h0, ind}, fx(2'b11, 16'ha5a4));
      n0 = m.reqs;
      go(mk(MOVE_WORD_IMMEDIATE_OP_REG, 3'h6, 3'h1, AM_DISP, 1'b0, 16'h0100, 16'h0));
      chk(result_word, 16'h0140);
      chk({14'h0, ci, cs}, 16'h0);
      chk(16'(m.reqs - n0), 16'h0);
      n0 = m.reqs;
      go(mk(MOVE_WORD_IMMEDIATE_OP_STOR, 3'h0, 3'h1, AM_REG, 1'b0, 16'h0, 16'h0007));
      chk(m.words[8'h20], 16'h0007);
      chk(16'(m.reqs - n0), 16'h1);
      m.words[8'h02] = 16'h0008;
      n0 = m.reqs;
      go(mk(MOVE_WORD_IMMEDIATE_OP_STOR, 3'h0, 3'h1, AM_DISP, 1'b0, 16'h0008, 16'h7ffe));
      chk(m.words[8'h24], 16'h7ffe);
      chk(16'(m.reqs - n0), 16'h2);
      chk({11'h0, ind}, fx(2'b11, 16'h7ffe));
      m.words[8'h26] = 16'h5555;
      go(mk(MOVE_WORD_THEN_CLEAR_OP, 3'h4, 3'h1, AM_DISP, 1'b0, 16'h000c, 16'h0));
      chk(result_word, 16'h5555);
      chk(m.words[8'h26], 16'h0000);
      ld(3'h3, 16'h0003);
      m.words[8'h27] = 16'h0005;
      go(mk(MULTIPLY_WORD_OP, 3'h3, 3'h1, AM_DISP, 1'b0, 16'h000e, 16'h0));
      chk(result_word, 16'h000f);
      chk({11'h0, ind}, fx(2'b10, 16'h000f));
      m.words[8'h27] = 16'h7000;
      go(mk(MULTIPLY_WORD_OP, 3'h3, 3'h1, AM_DISP, 1'b0, 16'h000e, 16'h0));
      chk({14'h0, ind.carry, ind.overflow}, 16'h3);
      fl();
      m.words[8'h2a] = 16'h0061;
      r0 = result_word;
      go(mk(MOVE_WORD_SHORT_OP_LOAD, 3'h4, 3'h1, AM_REG, 1'b1, 16'h000a, 16'h0));
      chk({14'h0, ci, cs}, 16'h1);
      chk(result_word, r0);
      go(mk(MOVE_WORD_SHORT_OP_LOAD, 3'h4, 3'h7, AM_REG, 1'b0, 16'h0, 16'h0));
      chk({14'h0, ci, cs}, 16'h2);
      i = mk(MOVE_WORD_OP_LONG, 3'h5, 3'h1, AM_REG, 1'b0, 16'h0020, 16'h0);
      i.instr_addr = 16'h00fe;
      go(i);
      chk({14'h0, ci, cs}, 16'h2);
      chk({11'h0, ind}, 16'h0018);
      i.op = MOVE_WORD_SHORT_OP_LOAD;
      i.instr_addr = 16'h0200;
      go(i);
      chk({14'h0, ci, cs}, 16'h0);
      chk(result_word, 16'h0007);
      m.words[8'h2b] = 16'h0050;
      go(mk(MOVE_WORD_THEN_CLEAR_OP, 3'h6, 3'h1, AM_IND, 1'b0, 16'h0016, 16'h0));
      chk(result_word, 16'ha5a4);
      chk(m.words[8'h28], 16'h0000);
      go(mk(MOVE_WORD_IMMEDIATE_OP_REG, 3'h6, 3'h1, AM_IND, 1'b0, 16'h0015, 16'h0));
      chk({14'h0, ci, cs}, 16'h1);
      chk(result_word, 16'ha5a4);
      wrap_up();
   end
endmodule : word_move_multiply_exec_test
